/* out_fault_regs.svh */
// Constants for the output fault state control block
// Summary of operation
// - Each channel holds program-mode settings off, on or hold, and fault-mode settings off, on, hold or user value.
// - On connection loss each output takes its fault behaviour on the third clock edge after conn_ok drops.
// - Hold-last-state keeps its value until the connection returns or a finite duration expires.
// - Unlimited duration keeps the fault value while the connection stays broken.
// - Finite duration expiry with connection still broken drives the final value.
// - Duration choices: unlimited, 1 s, 2 s, 5 s, 10 s.
// - Controller supplies per-point final value; device drives it after expiry.
// - Connection return makes every output follow commanded data again.
// - Output reaches new state within 100 us, or 10 us for the fast variant.
`ifndef OUT_FAULT_REGS_SVH
`define OUT_FAULT_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define CHANGE_TIME_STD_NS 100000
`define CHANGE_TIME_FAST_NS 10000
`define CHANGE_CYC_STD (`CHANGE_TIME_STD_NS / `CLK_PERIOD_NS)
`define CHANGE_CYC_FAST (`CHANGE_TIME_FAST_NS / `CLK_PERIOD_NS)
`define DUR_1S_MS 1000
`define DUR_2S_MS 2000
`define DUR_5S_MS 5000
`define DUR_10S_MS 10000
`define MS_NS 1000000
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// Output state encodings
// ----------------------------------------
`define OSEL_OFF 2'h0
`define OSEL_ON 2'h1
`define OSEL_HOLD 2'h2
`define OSEL_USER 2'h3

// ----------------------------------------
// Duration encodings
// ----------------------------------------
`define DUR_FOREVER 3'h0
`define DUR_1S 3'h1
`define DUR_2S 3'h2
`define DUR_5S 3'h3
`define DUR_10S 3'h4

`endif

/* out_fault_pkg.sv */
// Types for the output fault state control block
package out_fault_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PROG = 2'b01,
    ST_FAULT = 2'b10,
    ST_FINAL = 2'b11
  } mode_e;
endpackage

/* ms_tick.sv */
// Millisecond tick generator
`timescale 1ns/1ns
`default_nettype none
`include "out_fault_regs.svh"
module ms_tick #(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_s;
  tick_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = 16'h0000;
    end else if (s_d.cnt == 16'(CYC_PER_MS - 1)) begin
      s_d.cnt = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule
`default_nettype wire

/* out_fault_ctrl.sv */
// Per-channel output state control across program and connection fault modes
`timescale 1ns/1ns
`default_nettype none
`include "out_fault_regs.svh"
module out_fault_ctrl #(
  parameter int unsigned NCH = 16,
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Connection and mode
  input wire logic conn_ok,
  input wire logic prog_mode,
  // Command message
  input wire logic cmd_valid,
  input wire logic [NCH-1:0] cmd_data,
  // Per-channel configuration and shared fault duration
  input wire logic [2*NCH-1:0] prog_sel_cfg,
  input wire logic [2*NCH-1:0] fault_sel_cfg,
  input wire logic [NCH-1:0] fault_user_value_cfg,
  input wire logic [NCH-1:0] point_final_fault_value_cfg,
  input wire logic [2:0] fault_duration_cfg,
  // Outputs and status
  output logic [NCH-1:0] out_point,
  output logic [1:0] mode_state,
  output logic fault_expired
);
  typedef struct packed {
    logic conn_s1;
    logic conn_s2;
    logic prog_s1;
    logic prog_s2;
    out_fault_pkg::mode_e mode;
    logic [13:0] ms_cnt;
    logic [NCH-1:0] cmd;
    logic [NCH-1:0] outp;
  } ctl_s;
  ctl_s s_q, s_d;

  logic tick;
  logic [13:0] dur_ms;
  logic finite;

  // ----------------------------------------
  // Millisecond timebase, runs only in fault
  // ----------------------------------------
  ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(s_q.mode == out_fault_pkg::ST_FAULT),
    .tick(tick)
  );

  // Duration decode
  always_comb begin
    finite = 1'b1;
    unique case (fault_duration_cfg)
      `DUR_1S: dur_ms = 14'(`DUR_1S_MS);
      `DUR_2S: dur_ms = 14'(`DUR_2S_MS);
      `DUR_5S: dur_ms = 14'(`DUR_5S_MS);
      `DUR_10S: dur_ms = 14'(`DUR_10S_MS);
      default: begin
        dur_ms = 14'h0000;
        finite = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Mode sequencing and output selection
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.conn_s1 = conn_ok;
    s_d.conn_s2 = s_q.conn_s1;
    s_d.prog_s1 = prog_mode;
    s_d.prog_s2 = s_q.prog_s1;
    if (cmd_valid) begin
      s_d.cmd = cmd_data;
    end
    unique case (s_q.mode)
      out_fault_pkg::ST_RUN, out_fault_pkg::ST_PROG: begin
        if (!s_q.conn_s2) begin
          s_d.mode = out_fault_pkg::ST_FAULT;
          s_d.ms_cnt = 14'h0000;
        end else begin
          s_d.mode = s_q.prog_s2 ? out_fault_pkg::ST_PROG : out_fault_pkg::ST_RUN;
        end
      end
      out_fault_pkg::ST_FAULT: begin
        if (s_q.conn_s2) begin
          s_d.mode = out_fault_pkg::ST_RUN;
        end else if (finite && tick) begin
          s_d.ms_cnt = s_q.ms_cnt + 14'h0001;
          if (s_q.ms_cnt + 14'h0001 >= dur_ms) begin
            s_d.mode = out_fault_pkg::ST_FINAL;
          end
        end
      end
      out_fault_pkg::ST_FINAL: begin
        if (s_q.conn_s2) begin
          s_d.mode = out_fault_pkg::ST_RUN;
        end
      end
    endcase
    // Outputs follow the new mode in the same update
    for (int i = 0; i < NCH; i++) begin
      unique case (s_d.mode)
        out_fault_pkg::ST_RUN: s_d.outp[i] = s_d.cmd[i];
        out_fault_pkg::ST_PROG: begin
          unique case (prog_sel_cfg[2*i +: 2])
            `OSEL_OFF: s_d.outp[i] = 1'b0;
            `OSEL_ON: s_d.outp[i] = 1'b1;
            default: s_d.outp[i] = s_q.outp[i];
          endcase
        end
        out_fault_pkg::ST_FAULT: begin
          unique case (fault_sel_cfg[2*i +: 2])
            `OSEL_OFF: s_d.outp[i] = 1'b0;
            `OSEL_ON: s_d.outp[i] = 1'b1;
            `OSEL_USER: s_d.outp[i] = fault_user_value_cfg[i];
            default: s_d.outp[i] = s_q.outp[i];
          endcase
        end
        out_fault_pkg::ST_FINAL: s_d.outp[i] = point_final_fault_value_cfg[i];
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.conn_s1 <= 1'b1;
      s_q.conn_s2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_point = s_q.outp;
  assign mode_state = s_q.mode;
  assign fault_expired = (s_q.mode == out_fault_pkg::ST_FINAL);

  // ----------------------------------------
  // Per-channel selection masks for the checks
  // ----------------------------------------
  logic [NCH-1:0] prog_off_mask;
  logic [NCH-1:0] prog_on_mask;
  logic [NCH-1:0] fault_off_mask;
  logic [NCH-1:0] fault_on_mask;
  logic [NCH-1:0] fault_hold_mask;
  logic [NCH-1:0] fault_user_mask;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      prog_off_mask[i] = (prog_sel_cfg[2*i +: 2] == `OSEL_OFF);
      prog_on_mask[i] = (prog_sel_cfg[2*i +: 2] == `OSEL_ON);
      fault_off_mask[i] = (fault_sel_cfg[2*i +: 2] == `OSEL_OFF);
      fault_on_mask[i] = (fault_sel_cfg[2*i +: 2] == `OSEL_ON);
      fault_hold_mask[i] = (fault_sel_cfg[2*i +: 2] == `OSEL_HOLD);
      fault_user_mask[i] = (fault_sel_cfg[2*i +: 2] == `OSEL_USER);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_run_follows_cmd: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_RUN && s_q.conn_s2 && !s_q.prog_s2 && cmd_valid)
    |=> out_point == $past(cmd_data))
    else $error("Run mode output not following command");
  a_loss_enters_fault: assert property (@(posedge clk_sys) disable iff (rst)
    (!s_q.conn_s2 && s_q.mode inside {out_fault_pkg::ST_RUN, out_fault_pkg::ST_PROG})
    |=> s_q.mode == out_fault_pkg::ST_FAULT)
    else $error("Connection loss not entering fault");
  a_forever_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_FAULT && !finite && !s_q.conn_s2)
    |=> s_q.mode == out_fault_pkg::ST_FAULT)
    else $error("Unlimited fault left while broken");
  a_final_value: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.mode == out_fault_pkg::ST_FINAL |-> out_point == $past(point_final_fault_value_cfg))
    else $error("Final value not driven");
  a_return_run: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.conn_s2 && s_q.mode inside {out_fault_pkg::ST_FAULT, out_fault_pkg::ST_FINAL})
    |=> s_q.mode == out_fault_pkg::ST_RUN)
    else $error("Connection return not resuming");
  a_expiry_time: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_FAULT && finite && s_q.ms_cnt >= dur_ms) |-> 1'b0)
    else $error("Fault duration overrun");
  a_hold_fault: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_FAULT && $past(s_q.mode) == out_fault_pkg::ST_FAULT)
    |-> ((out_point ^ $past(out_point)) & $past(fault_hold_mask)) == '0)
    else $error("Hold last state changed");
  a_prog_off: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_PROG && $past(prog_sel_cfg[1:0]) == `OSEL_OFF) |-> !out_point[0])
    else $error("Program off not applied");
  a_prog_on_off: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.mode == out_fault_pkg::ST_PROG |->
      ((out_point & $past(prog_off_mask)) == '0 && (out_point & $past(prog_on_mask)) == $past(prog_on_mask)))
    else $error("Program selection not applied");
  a_fault_sel: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.mode == out_fault_pkg::ST_FAULT |->
      ((out_point & $past(fault_off_mask)) == '0 && (out_point & $past(fault_on_mask)) == $past(fault_on_mask)
       && ((out_point ^ $past(fault_user_value_cfg)) & $past(fault_user_mask)) == '0))
    else $error("Fault selection not applied");
  a_final_stays: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_FINAL && !s_q.conn_s2)
    |=> s_q.mode == out_fault_pkg::ST_FINAL)
    else $error("Final state left while broken");
  a_loss_restarts: assert property (@(posedge clk_sys) disable iff (rst)
    (!s_q.conn_s2 && s_q.mode inside {out_fault_pkg::ST_RUN, out_fault_pkg::ST_PROG})
    |=> s_q.ms_cnt == 14'h0000)
    else $error("Fault timer not restarted");
  a_prog_entry: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_RUN && s_q.conn_s2 && s_q.prog_s2)
    |=> s_q.mode == out_fault_pkg::ST_PROG)
    else $error("Program mode not entered");
  a_prog_exit: assert property (@(posedge clk_sys) disable iff (rst)
    (s_q.mode == out_fault_pkg::ST_PROG && s_q.conn_s2 && !s_q.prog_s2)
    |=> s_q.mode == out_fault_pkg::ST_RUN)
    else $error("Program mode not left");
endmodule
`default_nettype wire

/* owner_ctrl_model.sv */
// Owner controller model: connection state and command messages
`timescale 1ns/1ns
`default_nettype none
module owner_ctrl_model #(
  parameter int unsigned NCH = 4
) (
  // Clock
  input wire logic clk_sys,
  // Connection and commands
  output logic conn_ok,
  output logic cmd_valid,
  output logic [NCH-1:0] cmd_data
);
  initial begin
    conn_ok = 1'h1;
    cmd_valid = 1'h0;
    cmd_data = '0;
  end

  // Raise a command; back to back calls keep valid high
  task automatic send(input logic [NCH-1:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_data <= d;
  endtask

  // Stale data is inverted so it never looks valid
  task automatic idle();
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    cmd_data <= ~cmd_data;
  endtask

  task automatic link(input logic up);
    @(posedge clk_sys);
    conn_ok <= up;
  endtask
endmodule
`default_nettype wire

/* output_fault_state_control_tb.sv */
// Testbench for the output fault state control block
`timescale 1ns/1ns
`default_nettype none
module output_fault_state_control_tb;
  localparam int unsigned NCH = 4;
  localparam int unsigned CPM = 2;
  localparam int SEC = 1000 * CPM;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic conn_ok, prog_mode, cmd_valid, fault_expired;
  logic [NCH-1:0] cmd_data, user_val, final_val, out_point;
  logic [2*NCH-1:0] prog_sel, fault_sel;
  logic [2:0] dur;
  logic [1:0] mode_state;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 clk_sys = ~clk_sys;

  owner_ctrl_model #(.NCH(NCH)) owner (.clk_sys(clk_sys), .conn_ok(conn_ok), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data));

  out_fault_ctrl #(.NCH(NCH), .CYC_PER_MS(CPM)) dut (.clk_sys(clk_sys), .rst(rst), .conn_ok(conn_ok),
    .prog_mode(prog_mode), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .prog_sel_cfg(prog_sel),
    .fault_sel_cfg(fault_sel), .fault_user_value_cfg(user_val), .point_final_fault_value_cfg(final_val),
    .fault_duration_cfg(dur), .out_point(out_point), .mode_state(mode_state), .fault_expired(fault_expired));

  // ----
  // Helpers
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_state(input logic [3:0] o, input out_fault_pkg::mode_e m);
    check(out_point, o);
    check(4'(mode_state), 4'(m));
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic run_cmds();
    owner.send(4'h3);
    owner.send(4'h5);
    owner.idle();
    tick(1);
    expect_state(4'h5, out_fault_pkg::ST_RUN);
  endtask

  task automatic fault_forever();
    owner.link(1'h0);
    tick(3);
    expect_state(4'he, out_fault_pkg::ST_FAULT);
    owner.send(4'ha);
    owner.idle();
    tick(3 * SEC);
    expect_state(4'he, out_fault_pkg::ST_FAULT);
    check(4'(fault_expired), 4'h0);
    owner.link(1'h1);
    tick(3);
    expect_state(4'ha, out_fault_pkg::ST_RUN);
  endtask

  task automatic fault_final();
    int secs[4] = '{1, 2, 5, 10};
    logic [3:0] finals[4] = '{4'ha, 4'h3, 4'hc, 4'h6};
    owner.send(4'h5);
    owner.idle();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      dur <= 3'(i + 1);
      final_val <= finals[i];
      owner.link(1'h0);
      tick(secs[i] * SEC - 20);
      expect_state(4'he, out_fault_pkg::ST_FAULT);
      tick(40);
      expect_state(finals[i], out_fault_pkg::ST_FINAL);
      check(4'(fault_expired), 4'h1);
      owner.link(1'h1);
      tick(3);
      expect_state(4'h5, out_fault_pkg::ST_RUN);
    end
  endtask

  task automatic fault_cancel();
    @(posedge clk_sys);
    dur <= 3'h1;
    fault_sel <= 8'h1b;
    user_val <= 4'h0;
    final_val <= 4'h9;
    owner.link(1'h0);
    tick(SEC / 2);
    owner.link(1'h1);
    tick(3);
    expect_state(4'h5, out_fault_pkg::ST_RUN);
    owner.link(1'h0);
    tick(SEC - 20);
    expect_state(4'h4, out_fault_pkg::ST_FAULT);
    tick(40);
    expect_state(4'h9, out_fault_pkg::ST_FINAL);
    owner.link(1'h1);
    tick(3);
  endtask

  task automatic prog_entry();
    @(posedge clk_sys);
    prog_mode <= 1'h1;
    tick(3);
    expect_state(4'h6, out_fault_pkg::ST_PROG);
    @(posedge clk_sys);
    prog_mode <= 1'h0;
    prog_sel <= 8'h4b;
    tick(3);
    expect_state(4'h5, out_fault_pkg::ST_RUN);
    @(posedge clk_sys);
    prog_mode <= 1'h1;
    tick(3);
    expect_state(4'h9, out_fault_pkg::ST_PROG);
  endtask

  // ----
  // Sequence and timeout
  // ----
  initial begin
    prog_mode = 1'h0;
    prog_sel = 8'he4;
    fault_sel = 8'he4;
    user_val = 4'h8;
    final_val = 4'ha;
    dur = 3'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    run_cmds();
    fault_forever();
    fault_final();
    fault_cancel();
    prog_entry();
    report_and_stop();
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
